// *** rtl/ekrc_map.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef EKRC_MAP_SVH
`define EKRC_MAP_SVH
`define EKRC_KNEE_IDX        8'h0A
`define EKRC_TOTAL_IDX       8'h0B
`define EKRC_RESET_IDX       8'h0C
`define EKRC_BIN_IDX         8'h0D
`define EKRC_KNEE1_IDX       8'h08
`define EKRC_KNEE2_IDX       8'h09
`define EKRC_CTRL_IDX        8'h10
`define EKRC_STAT_IDX        8'h11
`define EKRC_T2_LSB          0
`define EKRC_T3_LSB          4
`define EKRC_AUTO_BIT        8
`define EKRC_SINGLE_BIT      9
`define EKRC_SOFT_BIT        0
`define EKRC_AUTOBLK_BIT     1
`define EKRC_HDR_BIT         0
`define EKRC_AEC_BIT         1
`define EKRC_T2_RST          4'h4
`define EKRC_T3_RST          4'h6
`define EKRC_AUTO_RST        1'h1
`define EKRC_SINGLE_RST      1'h0
`define EKRC_TOTAL_RST       15'h01E0
`define EKRC_KNEE1_RST       15'h01BB
`define EKRC_KNEE2_RST       15'h01D9
`define EKRC_BIN_RST         2'h0
`define EKRC_RST_CYCLES      15
`endif

// *** rtl/ekrc_pkg.sv ***
// types for the exposure knee and readout control block
package ekrc_pkg;
  typedef enum logic [1:0] {
    EKRC_BIN_NONE = 2'b00,
    EKRC_BIN_TWO  = 2'b01,
    EKRC_BIN_FOUR = 2'b10,
    EKRC_BIN_BAD  = 2'b11
  } ekrc_bin_e;
  typedef struct packed {
    logic [14:0] total;
    logic [14:0] knee1;
    logic [14:0] knee2;
  } ekrc_expo_s;
  typedef struct packed {
    logic [3:0] second_slope_ratio;
    logic [3:0] third_slope_ratio;
    logic       auto_knee;
    logic       single_knee;
  } ekrc_knee_s;
endpackage

// *** rtl/ekrc_reset_pulse.sv ***
// self-timed active-low reset pulse generator
`timescale 1ns/10ps
`default_nettype none
`include "ekrc_map.svh"
module ekrc_reset_pulse
  import ekrc_pkg::*;
#(
  parameter int CYCLES = `EKRC_RST_CYCLES
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic fire,
  output var  logic rst_n
);
  // refused at elaboration: the 8-bit counter cannot hold it
  if (CYCLES < 1 || CYCLES > 255)
  begin : g_bad_cycles
    $error("reset pulse length out of range");
  end

  logic [7:0] count_reg;

  // a new write restarts the full length
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_reg <= 8'h00;
    else if (fire)
      count_reg <= 8'(CYCLES);
    else if (count_reg != 8'h00)
      count_reg <= count_reg - 8'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_n <= 1'b1;
    else
      rst_n <= !(fire || count_reg > 8'h01);
  end
endmodule
`default_nettype wire

// *** rtl/ekrc_top.sv ***
// exposure knee, integration, reset pulse and binning control with apb slave
//
// Notes on behaviour
// - t2 equals total times half power ratio
// - t3 equals total times half power ratio
// - t1 equals total minus t2 minus t3
// - knee ratio writes apply from next frame
// - bit 8 enables auto knee, default one
// - bit 9 enables single knee, default zero
// - total rows 15 bits, default 1E0, next frame
// - soft reset abandons frame, keeps port config
// - reset bits self clear, pulse 15 cycles
// - auto block reset hits only auto exposure
// - binning 0 normal, 1 two rows, 2 four
// - binning divides height, pixel rate unchanged
// - manual knees from two 15-bit registers
`timescale 1ns/10ps
`default_nettype none
`include "ekrc_map.svh"
module ekrc_top
  import ekrc_pkg::*;
#(
  parameter int ROWS = 480
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        frame_start,
  input  wire logic [14:0] aec_total,
  output var  logic [14:0] t1_rows,
  output var  logic [14:0] t2_rows,
  output var  logic [14:0] t3_rows,
  output var  logic        hdr_active,
  output var  logic        single_knee,
  output var  logic [9:0]  out_height,
  output var  logic [1:0]  rows_per_out,
  output var  logic        core_rst_n,
  output var  logic        aec_rst_n
);
  // refused at elaboration: height output is 10 bits
  if (ROWS < 4 || ROWS > 1023)
  begin : g_bad_rows
    $error("row count out of range");
  end

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  ekrc_knee_s knee_reg;
  ekrc_expo_s expo_reg;
  ekrc_bin_e  bin_reg;
  logic       hdr_en_reg;
  logic       aec_en_reg;
  logic [1:0] pulse_reg;
  logic       frame_count_reg;

  logic       acc;
  logic       wr;
  logic [7:0] idx;
  logic       mapped;
  assign acc = psel && penable;
  assign wr  = acc && pwrite;
  assign idx = paddr[9:2];
  always_comb
  begin
    unique case (idx)
      `EKRC_KNEE_IDX, `EKRC_TOTAL_IDX, `EKRC_RESET_IDX, `EKRC_BIN_IDX,
      `EKRC_KNEE1_IDX, `EKRC_KNEE2_IDX, `EKRC_CTRL_IDX, `EKRC_STAT_IDX:
        mapped = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
      default:
        mapped = 1'b0;
    endcase
  end

  // software writes stay local until frame start; no shadow copy is read back
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      knee_reg <= '{`EKRC_T2_RST, `EKRC_T3_RST, `EKRC_AUTO_RST, `EKRC_SINGLE_RST};
      expo_reg <= '{`EKRC_TOTAL_RST, `EKRC_KNEE1_RST, `EKRC_KNEE2_RST};
    end
    else if (wr && mapped)
    begin
      if (idx == `EKRC_KNEE_IDX)
      begin
        knee_reg.second_slope_ratio    <= pwdata[`EKRC_T2_LSB +: 4];
        knee_reg.third_slope_ratio    <= pwdata[`EKRC_T3_LSB +: 4];
        knee_reg.auto_knee   <= pwdata[`EKRC_AUTO_BIT];
        knee_reg.single_knee <= pwdata[`EKRC_SINGLE_BIT];
      end
      if (idx == `EKRC_TOTAL_IDX)
        expo_reg.total <= pwdata[14:0];
      if (idx == `EKRC_KNEE1_IDX)
        expo_reg.knee1 <= pwdata[14:0];
      if (idx == `EKRC_KNEE2_IDX)
        expo_reg.knee2 <= pwdata[14:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bin_reg    <= EKRC_BIN_NONE;
      hdr_en_reg <= 1'b0;
      aec_en_reg <= 1'b0;
    end
    else if (wr && mapped)
    begin
      if (idx == `EKRC_BIN_IDX)
        bin_reg <= ekrc_bin_e'(pwdata[1:0]);
      if (idx == `EKRC_CTRL_IDX)
      begin
        hdr_en_reg <= pwdata[`EKRC_HDR_BIT];
        aec_en_reg <= pwdata[`EKRC_AEC_BIT];
      end
    end
  end

  // self-clearing: the bits are stored for one cycle only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_reg <= 2'b00;
    else if (wr && mapped && idx == `EKRC_RESET_IDX)
      pulse_reg <= {pwdata[`EKRC_AUTOBLK_BIT], pwdata[`EKRC_SOFT_BIT]};
    else
      pulse_reg <= 2'b00;
  end

  // ----------------------------------------------------------------
  // reset pulses
  // ----------------------------------------------------------------
  ekrc_reset_pulse #(.CYCLES(`EKRC_RST_CYCLES)) u_core_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .fire    (pulse_reg[0]),
    .rst_n   (core_rst_n)
  );
  ekrc_reset_pulse #(.CYCLES(`EKRC_RST_CYCLES)) u_aec_rst (
    .pclk    (pclk),
    .presetn (presetn),
    .fire    (pulse_reg[0] || pulse_reg[1]),
    .rst_n   (aec_rst_n)
  );

  // ----------------------------------------------------------------
  // per-frame exposure computation
  // ----------------------------------------------------------------
  logic [14:0] total_sel;
  logic [14:0] t2_calc;
  logic [14:0] t3_calc;
  assign total_sel = aec_en_reg ? aec_total : expo_reg.total;
  assign t2_calc   = total_sel >> knee_reg.second_slope_ratio;
  assign t3_calc   = total_sel >> knee_reg.third_slope_ratio;

  // soft reset holds outputs at defaults, abandoning the frame
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      t1_rows     <= 15'h0000;
      t2_rows     <= 15'h0000;
      t3_rows     <= 15'h0000;
      hdr_active  <= 1'b0;
      single_knee <= 1'b0;
    end
    else if (!core_rst_n)
    begin
      t1_rows     <= 15'h0000;
      t2_rows     <= 15'h0000;
      t3_rows     <= 15'h0000;
      hdr_active  <= 1'b0;
      single_knee <= 1'b0;
    end
    else if (frame_start)
    begin
      hdr_active  <= hdr_en_reg;
      single_knee <= knee_reg.single_knee;
      if (knee_reg.auto_knee)
      begin
        t2_rows <= t2_calc;
        t3_rows <= t3_calc;
        t1_rows <= total_sel - t2_calc - t3_calc;
      end
      else
      begin
        t1_rows <= expo_reg.knee1;
        t2_rows <= expo_reg.knee2 - expo_reg.knee1;
        t3_rows <= total_sel - expo_reg.knee2;
      end
    end
  end

  // binning applied per frame; pixel clock untouched, only rows shrink
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_height   <= 10'(ROWS);
      rows_per_out <= 2'h0;
    end
    else if (frame_start)
    begin
      unique case (bin_reg)
        EKRC_BIN_TWO:
        begin
          out_height   <= 10'(ROWS / 2);
          rows_per_out <= 2'h1;
        end
        EKRC_BIN_FOUR:
        begin
          out_height   <= 10'(ROWS / 4);
          rows_per_out <= 2'h3;
        end
        default:
        begin
          out_height   <= 10'(ROWS);
          rows_per_out <= 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_count_reg <= 1'b0;
    else if (frame_start)
      frame_count_reg <= !frame_count_reg;
  end

  // ----------------------------------------------------------------
  // apb answer, one wait-free access cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite && mapped)
      begin
        unique case (idx)
          `EKRC_KNEE_IDX:
            prdata <= {22'h000000, knee_reg.single_knee, knee_reg.auto_knee,
                       knee_reg.third_slope_ratio, knee_reg.second_slope_ratio};
          `EKRC_TOTAL_IDX:
            prdata <= {17'h00000, expo_reg.total};
          `EKRC_KNEE1_IDX:
            prdata <= {17'h00000, expo_reg.knee1};
          `EKRC_KNEE2_IDX:
            prdata <= {17'h00000, expo_reg.knee2};
          `EKRC_BIN_IDX:
            prdata <= {30'h00000000, bin_reg};
          `EKRC_CTRL_IDX:
            prdata <= {30'h00000000, aec_en_reg, hdr_en_reg};
          `EKRC_STAT_IDX:
            prdata <= {28'h0000000, frame_count_reg, aec_rst_n, core_rst_n, hdr_active};
          default: // reset register reads zero
            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // cycles since the last soft reset write, saturating; long pulses are counted, not unrolled
  logic [4:0] soft_age_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      soft_age_reg <= 5'h1F;
    else if (wr && mapped && idx == `EKRC_RESET_IDX && pwdata[`EKRC_SOFT_BIT])
      soft_age_reg <= 5'h00;
    else if (soft_age_reg != 5'h1F)
      soft_age_reg <= soft_age_reg + 5'h01;
  end

  sequence s_soft_write;
    wr && mapped && idx == `EKRC_RESET_IDX && pwdata[`EKRC_SOFT_BIT];
  endsequence

  chk_soft_pulse_len: assert property (@(posedge pclk) disable iff (!presetn)
    s_soft_write |-> ##2 (!core_rst_n) [*8])
    else $error("soft reset pulse too short");
  chk_soft_pulse_end: assert property (@(posedge pclk) disable iff (!presetn)
    (soft_age_reg >= 5'h08 && soft_age_reg <= 5'h10) |-> core_rst_n == (soft_age_reg == 5'h10))
    else $error("soft reset pulse wrong length");
  chk_aec_only_rst: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && mapped && idx == `EKRC_RESET_IDX && pwdata[1:0] == 2'b10 && core_rst_n && !pulse_reg[0])
    |-> ##3 (!aec_rst_n && core_rst_n))
    else $error("auto block reset wrong scope");
  chk_reset_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && !pwrite && idx == `EKRC_RESET_IDX) |=> prdata == 32'h0000_0000)
    else $error("reset register read nonzero");
  chk_hold_mid_frame: assert property (@(posedge pclk) disable iff (!presetn)
    (!frame_start && core_rst_n) |=> $stable(t2_rows) && $stable(t3_rows))
    else $error("knee timing changed mid frame");
  chk_auto_t2: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_start && core_rst_n && knee_reg.auto_knee) |=> t2_rows == $past(t2_calc))
    else $error("second slope wrong");
  chk_auto_sum: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_start && core_rst_n && knee_reg.auto_knee) |=> 15'(t1_rows + t2_rows + t3_rows) == $past(total_sel))
    else $error("slopes do not sum to total");
  chk_manual_knee: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_start && core_rst_n && !knee_reg.auto_knee) |=> t1_rows == $past(expo_reg.knee1))
    else $error("manual knee not applied");
  chk_manual_total: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_start && core_rst_n && knee_reg.auto_knee && !aec_en_reg)
    |=> 15'(t1_rows + t2_rows + t3_rows) == $past(expo_reg.total))
    else $error("manual total not used");
  chk_bin_height: assert property (@(posedge pclk) disable iff (!presetn)
    (frame_start && bin_reg == EKRC_BIN_FOUR) |=> out_height == 10'(ROWS / 4) && rows_per_out == 2'h3)
    else $error("binning height wrong");
endmodule
`default_nettype wire

// *** verification/tb.sv ***
// self-checking testbench for the exposure knee and readout control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ekrc_pkg::*;
  localparam int ROWS = 480;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        frame_start;
  logic [14:0] aec_total;
  logic [14:0] t1_rows;
  logic [14:0] t2_rows;
  logic [14:0] t3_rows;
  logic        hdr_active;
  logic        single_knee;
  logic [9:0]  out_height;
  logic [1:0]  rows_per_out;
  logic        core_rst_n;
  logic        aec_rst_n;
  logic [31:0] rd;
  logic        err;
  int          fails;
  int          n_checks;

  ekrc_top #(.ROWS(ROWS)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frame_start(frame_start), .aec_total(aec_total), .t1_rows(t1_rows),
    .t2_rows(t2_rows), .t3_rows(t3_rows), .hdr_active(hdr_active), .single_knee(single_knee),
    .out_height(out_height), .rows_per_out(rows_per_out), .core_rst_n(core_rst_n),
    .aec_rst_n(aec_rst_n));

  // ---------------------------------
  // clock and shared tasks
  // ---------------------------------
  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // each transfer starts on a fresh edge, so a release never meets the next setup
  // no wait limit here: a slave that never answers is caught by the watchdog
  task automatic apb(input logic is_wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= is_wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, err}, {31'h0, experr});
  endtask

  task automatic frame();
    @(posedge pclk);
    frame_start <= 1'b1;
    @(posedge pclk);
    frame_start <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic slopes(input logic [14:0] e1, input logic [14:0] e2, input logic [14:0] e3);
    chk({17'h0, t1_rows}, {17'h0, e1});
    chk({17'h0, t2_rows}, {17'h0, e2});
    chk({17'h0, t3_rows}, {17'h0, e3});
  endtask

  // ---------------------------------
  // scenarios
  // ---------------------------------
  task automatic t_reset_values();
    rdc(12'h028, 32'h0000_0164, 1'b0);
    rdc(12'h02C, 32'h0000_01E0, 1'b0);
    rdc(12'h030, 32'h0000_0000, 1'b0);
    rdc(12'h034, 32'h0000_0000, 1'b0);
    rdc(12'h020, 32'h0000_01BB, 1'b0);
    rdc(12'h024, 32'h0000_01D9, 1'b0);
    rdc(12'h03C, 32'h0000_0000, 1'b1);
    rdc(12'h029, 32'h0000_0000, 1'b1);
  endtask

  task automatic t_auto_knee();
    wr(12'h040, 32'h0000_0001);
    frame();
    slopes(15'h01BB, 15'h001E, 15'h0007);
    chk({31'h0, hdr_active}, 32'h1);
    wr(12'h028, 32'h0000_0121);
    wr(12'h02C, 32'h0000_0100);
    repeat (3) @(posedge pclk);
    chk({17'h0, t2_rows}, 32'h1E);
    chk({17'h0, t1_rows}, 32'h1BB);
    frame();
    slopes(15'h0040, 15'h0080, 15'h0040);
  endtask

  task automatic t_manual_knee();
    wr(12'h020, 32'h0000_0010);
    wr(12'h024, 32'h0000_0030);
    wr(12'h028, 32'h0000_0200);
    frame();
    slopes(15'h0010, 15'h0020, 15'h00D0);
    chk({31'h0, single_knee}, 32'h1);
  endtask

  task automatic t_aec_total();
    aec_total <= 15'h0080;
    wr(12'h040, 32'h0000_0003);
    wr(12'h028, 32'h0000_0111);
    frame();
    slopes(15'h0000, 15'h0040, 15'h0040);
    chk({31'h0, single_knee}, 32'h0);
    rdc(12'h040, 32'h0000_0003, 1'b0);
    rdc(12'h044, 32'h0000_0007, 1'b0);
  endtask

  // soft reset also pulls the auto block reset, and forces the slopes to zero
  task automatic t_pulse(input int b);
    int n;
    int low;
    int other;
    wr(12'h030, 32'h0000_0001 << b);
    n = 0;
    while ((b == 0 ? core_rst_n : aec_rst_n) !== 1'b0 && n < 10)
    begin
      @(posedge pclk);
      n++;
    end
    low = 0;
    other = 0;
    while ((b == 0 ? core_rst_n : aec_rst_n) === 1'b0 && low < 40)
    begin
      if (b == 0 && (aec_rst_n !== 1'b0 || (low > 0 && t2_rows !== 15'h0)))
        other++;
      if (b == 1 && core_rst_n !== 1'b1)
        other++;
      @(posedge pclk);
      low++;
    end
    chk(low, 32'd15);
    chk(other, 32'd0);
    rdc(12'h030, 32'h0000_0000, 1'b0);
  endtask

  task automatic t_binning();
    logic [9:0] h[4];
    logic [1:0] r[4];
    h = '{10'(ROWS), 10'(ROWS / 2), 10'(ROWS / 4), 10'(ROWS)};
    r = '{2'h0, 2'h1, 2'h3, 2'h0};
    for (int b = 0; b < 3; b++)
    begin
      wr(12'h034, b);
      frame();
      chk({22'h0, out_height}, {22'h0, h[b]});
      chk({30'h0, rows_per_out}, {30'h0, r[b]});
      rdc(12'h034, b, 1'b0);
    end
  endtask

  // ---------------------------------
  // main sequence and watchdog
  // ---------------------------------
  initial
  begin
    fails = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    frame_start = 1'b0;
    aec_total = 15'h0000;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values();
    t_auto_knee();
    t_manual_knee();
    t_aec_total();
    t_pulse(1);
    t_pulse(0);
    t_binning();
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    fails++;
    stop_test();
  end
endmodule
`default_nettype wire
